// ### verilog/vemi_consts.vh
// Constants for the video encoder input and mode select block
`ifndef VEMI_CONSTS_VH
`define VEMI_CONSTS_VH
`define VEMI_APB_AW         12
`define VEMI_OFF_CTRL       12'h000
`define VEMI_OFF_STATUS     12'h004
`define VEMI_OFF_PIXEL      12'h008
`define VEMI_CTRL_W         4
`define VEMI_CTRL_RESET     4'h0
`define VEMI_BIT_FIELD      0
`define VEMI_BIT_625        1
`define VEMI_BIT_PHASE      2
`define VEMI_BIT_ALT        3
`define VEMI_NTSC_LINE_CLK  12'h6b4
`define VEMI_PAL_LINE_CLK   12'h6c0
`define VEMI_NTSC_FIELD_LN  10'h106
`define VEMI_PAL_FIELD_LN   10'h139
`define VEMI_VS_LINES       10'h003
`define VEMI_LINES_525_MAX  10'h11d
`define VEMI_FIFO_DEPTH     4
`define VEMI_FIFO_AW        2
`endif

// ### verilog/vemi_top.v
// Video encoder pixel input, sync timing and mode selection
`timescale 1ns/1ps
`include "vemi_consts.vh"

// Small FIFO between pixel capture and the register bus
module vemi_fifo #(
    parameter W  = 24,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          clock_i,
    input  wire          reset_n_i,
    input  wire          clear_i,
    input  wire [W-1:0]  in_data_i,
    input  wire          in_valid_i,
    output wire          in_ready_o,
    output wire [W-1:0]  out_data_o,
    output wire          out_valid_o,
    input  wire          out_ready_i
);
    reg [W-1:0]  mem_reg [0:D-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0]   cnt_reg;
    wire         push;
    wire         pop;
    assign in_ready_o  = (cnt_reg != D[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem_reg[rd_reg];
    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    always @(posedge clock_i) begin
        if (push)
            mem_reg[wr_reg] <= in_data_i;
    end
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else if (clear_i) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

// ***************************************************************
// ***************************************************************
module vemi_top (
    input  wire        clock_i,
    input  wire        reset_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [7:0]  pixel_data_i,
    input  wire        hsync_n_i,
    output reg         hsync_n_o,
    output reg         hsync_n_oe_o,
    input  wire        vsync_n_i,
    output reg         vsync_n_o,
    output reg         vsync_n_oe_o,
    input  wire        master_select_i,
    input  wire        chroma_order_swap_i,
    input  wire        luma_select_i,
    input  wire        sleep_i,
    input  wire        mode_pin_first_i,
    input  wire        mode_pin_second_i,
    output reg         luma_only_o,
    output reg         powered_down_o,
    output reg         line_count_625_o,
    output reg         pixel_clock_out_o
);
    // ***********************************************************
    // Pin synchronisers
    // ***********************************************************
    reg  [7:0] pin_s1_reg;
    reg  [7:0] pin_s2_reg;
    reg  [7:0] pix_s1_reg;
    reg  [7:0] pix_s2_reg;
    wire       m_pin   = pin_s2_reg[0];
    wire       cb_pin  = pin_s2_reg[1];
    wire       lu_pin  = pin_s2_reg[2];
    wire       sl_pin  = pin_s2_reg[3];
    wire       ma_pin  = pin_s2_reg[4];
    wire       mb_pin  = pin_s2_reg[5];
    wire       hs_in   = pin_s2_reg[6];
    wire       vs_in   = pin_s2_reg[7];
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_s1_reg <= 8'hff;
            pin_s2_reg <= 8'hff;
            pix_s1_reg <= 8'h00;
            pix_s2_reg <= 8'h00;
        end else begin
            pin_s1_reg <= {vsync_n_i, hsync_n_i, mode_pin_second_i,
                           mode_pin_first_i, sleep_i, luma_select_i,
                           chroma_order_swap_i, master_select_i};
            pin_s2_reg <= pin_s1_reg;
            pix_s1_reg <= pixel_data_i;
            pix_s2_reg <= pix_s1_reg;
        end
    end

    // ***********************************************************
    // Configuration and timing
    // ***********************************************************
    reg  [3:0]  cfg_reg;
    reg         cfg_loaded_reg;
    reg  [11:0] hcnt_reg;
    reg  [9:0]  vcnt_reg;
    reg  [9:0]  lines_reg;
    reg  [11:0] clks_reg;
    reg         det625_reg;
    reg         field_reg;
    reg         hs_d_reg;
    reg         vs_d_reg;
    reg  [1:0]  phase_reg;
    reg  [7:0]  cb_reg;
    reg  [7:0]  y0_reg;
    reg  [7:0]  cr_reg;
    reg         pix_valid_reg;
    wire        fifo_ready;
    wire [23:0] fifo_data;
    wire        fifo_valid;
    wire        fifo_pop;
    wire        hs_fall = hs_d_reg & ~hs_in;
    wire        vs_fall = vs_d_reg & ~vs_in;
    wire        use625  = m_pin ? cfg_reg[`VEMI_BIT_625] : det625_reg;
    wire [11:0] line_end = use625 ? `VEMI_PAL_LINE_CLK : `VEMI_NTSC_LINE_CLK;
    wire [9:0]  fld_end  = use625 ? `VEMI_PAL_FIELD_LN : `VEMI_NTSC_FIELD_LN;
    // Slave line start is phase 0 in the cycle the synced fall shows
    wire [1:0]  phase_now = (!m_pin && hs_fall) ? 2'h0 : phase_reg;
    // Phase offset shifts the Y/chroma lock by one clock
    wire [1:0]  slot = phase_now + {1'b0, cfg_reg[`VEMI_BIT_PHASE]};
    wire        apb_wr = psel_i & penable_i & pwrite_i & ~pready_o;
    wire        apb_rd = psel_i & penable_i & ~pwrite_i & ~pready_o;

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_reg        <= `VEMI_CTRL_RESET;
            cfg_loaded_reg <= 1'b0;
            hcnt_reg       <= 12'h000;
            vcnt_reg       <= 10'h000;
            lines_reg      <= 10'h000;
            clks_reg       <= 12'h000;
            det625_reg     <= 1'b0;
            field_reg      <= 1'b0;
            hs_d_reg       <= 1'b1;
            vs_d_reg       <= 1'b1;
            phase_reg      <= 2'h0;
            cb_reg         <= 8'h00;
            y0_reg         <= 8'h00;
            cr_reg         <= 8'h00;
            pix_valid_reg  <= 1'b0;
        end else if (sl_pin) begin
            cfg_reg        <= `VEMI_CTRL_RESET;
            cfg_loaded_reg <= 1'b0;
            hcnt_reg       <= 12'h000;
            vcnt_reg       <= 10'h000;
            lines_reg      <= 10'h000;
            clks_reg       <= 12'h000;
            field_reg      <= 1'b0;
            phase_reg      <= 2'h0;
            pix_valid_reg  <= 1'b0;
        end else begin
            hs_d_reg <= hs_in;
            vs_d_reg <= vs_in;
            if (!cfg_loaded_reg) begin
                cfg_loaded_reg             <= 1'b1;
                cfg_reg[`VEMI_BIT_FIELD]   <= ma_pin;
                cfg_reg[`VEMI_BIT_625]     <= mb_pin;
                cfg_reg[`VEMI_BIT_ALT]     <= ma_pin & mb_pin;
            end else if (apb_wr && paddr_i == `VEMI_OFF_CTRL)
                cfg_reg <= pwdata_i[3:0];
            if (m_pin) begin
                if (hcnt_reg == line_end - 12'h001) begin
                    hcnt_reg <= 12'h000;
                    if (vcnt_reg == fld_end - 10'h001) begin
                        vcnt_reg  <= 10'h000;
                        field_reg <= ~field_reg;
                    end else
                        vcnt_reg <= vcnt_reg + 10'h001;
                end else
                    hcnt_reg <= hcnt_reg + 12'h001;
            end else begin
                clks_reg <= clks_reg + 12'h001;
                if (hs_fall) begin
                    hcnt_reg  <= 12'h000;
                    clks_reg  <= 12'h000;
                    lines_reg <= lines_reg + 10'h001;
                end else
                    hcnt_reg <= hcnt_reg + 12'h001;
                if (vs_fall) begin
                    det625_reg <= (lines_reg > `VEMI_LINES_525_MAX);
                    lines_reg  <= 10'h000;
                    vcnt_reg   <= 10'h000;
                    field_reg  <= (clks_reg > {1'b0, line_end[11:1]});
                end
            end
            // Pixel slot restarts with each line, slot 0 takes Cb, or Cr when the chroma order pin swaps it
            if (m_pin && hcnt_reg == line_end - 12'h001)
                phase_reg <= 2'h0;
            else
                phase_reg <= phase_now + 2'h1;
            pix_valid_reg <= 1'b0;
            case (slot)
                2'h0: begin
                    if (cb_pin)
                        cr_reg <= pix_s2_reg;
                    else
                        cb_reg <= pix_s2_reg;
                end
                2'h1: y0_reg <= pix_s2_reg;
                2'h2: begin
                    if (cb_pin)
                        cb_reg <= pix_s2_reg;
                    else
                        cr_reg <= pix_s2_reg;
                    pix_valid_reg <= 1'b1;
                end
                default: y0_reg <= y0_reg;
            endcase
        end
    end

    vemi_fifo #(
        .W  (24),
        .D  (`VEMI_FIFO_DEPTH),
        .AW (`VEMI_FIFO_AW)
    ) u_fifo (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .clear_i     (sl_pin),
        .in_data_i   ({cb_reg, y0_reg, cr_reg}),
        .in_valid_i  (pix_valid_reg),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );
    assign fifo_pop = apb_rd && paddr_i == `VEMI_OFF_PIXEL;

    // ***********************************************************
    // Outputs and APB slave
    // ***********************************************************
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hsync_n_o         <= 1'b1;
            hsync_n_oe_o      <= 1'b0;
            vsync_n_o         <= 1'b1;
            vsync_n_oe_o      <= 1'b0;
            luma_only_o       <= 1'b0;
            powered_down_o    <= 1'b1;
            line_count_625_o  <= 1'b0;
            pixel_clock_out_o <= 1'b0;
            prdata_o          <= 32'h00000000;
            pready_o          <= 1'b0;
            pslverr_o         <= 1'b0;
        end else begin
            hsync_n_oe_o <= m_pin & ~sl_pin;
            vsync_n_oe_o <= m_pin & ~sl_pin;
            hsync_n_o    <= ~(hcnt_reg < 12'h07e);
            if (cfg_reg[`VEMI_BIT_FIELD])
                vsync_n_o <= field_reg;
            else
                vsync_n_o <= ~(vcnt_reg < `VEMI_VS_LINES);
            luma_only_o       <= lu_pin;
            powered_down_o    <= sl_pin;
            line_count_625_o  <= use625;
            pixel_clock_out_o <= sl_pin ? 1'b0 : ~pixel_clock_out_o;
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= 1'b0;
            if (apb_rd) begin
                case (paddr_i)
                    `VEMI_OFF_CTRL:
                        prdata_o <= {28'h0000000, cfg_reg};
                    `VEMI_OFF_STATUS:
                        prdata_o <= {16'h0000, lines_reg, fifo_ready,
                                     fifo_valid, field_reg, det625_reg,
                                     m_pin, sl_pin};
                    `VEMI_OFF_PIXEL:
                        prdata_o <= {7'h00, fifo_valid, fifo_data};
                    default: begin
                        prdata_o  <= 32'h00000000;
                        pslverr_o <= 1'b1;
                    end
                endcase
            end else if (apb_wr) begin
                prdata_o <= 32'h00000000;
                if (paddr_i != `VEMI_OFF_CTRL)
                    pslverr_o <= 1'b1;
            end
        end
    end
endmodule

// ### test/vemi_props.sv
// Port checker for the encoder pixel input and mode select block
`timescale 1ns/1ps
module vemi_props (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        hsync_n_oe_o,
    input wire logic        vsync_n_oe_o,
    input wire logic        master_select_i,
    input wire logic        luma_select_i,
    input wire logic        sleep_i,
    input wire logic        luma_only_o,
    input wire logic        powered_down_o,
    input wire logic        pixel_clock_out_o
);
    // ***************************************************************
    // Port relations
    // ***************************************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    wire access = psel_i && penable_i && !pready_o;
    apb_answer_a: assert property (access |=> pready_o)
        else $error("no answer to access");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    bad_addr_a: assert property (access && paddr_i > 12'h008
        |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped accepted");
    ctrl_ok_a: assert property (access && paddr_i == 12'h000 |=> !pslverr_o)
        else $error("control refused");
    sleep_release_a: assert property (powered_down_o [*2] |->
        !hsync_n_oe_o && !vsync_n_oe_o) else $error("drives while asleep");
    sleep_clock_a: assert property (powered_down_o [*2] |->
        !pixel_clock_out_o) else $error("clock out while asleep");
    clock_toggle_a: assert property (!powered_down_o [*3] |->
        pixel_clock_out_o != $past(pixel_clock_out_o))
        else $error("clock out stuck");
    slave_release_a: assert property (!master_select_i [*5] |->
        !hsync_n_oe_o && !vsync_n_oe_o) else $error("slave drives sync");
    master_drive_a: assert property ((master_select_i && !sleep_i) [*6]
        |-> hsync_n_oe_o && vsync_n_oe_o) else $error("master idle");
    luma_follow_a: assert property (
        (!sleep_i && $stable(luma_select_i)) [*6]
        |-> luma_only_o == luma_select_i) else $error("luma select lost");
    sleep_follow_a: assert property ($stable(sleep_i) [*5] |->
        powered_down_o == sleep_i) else $error("sleep not followed");
endmodule

// ### test/vemi_decoder_model.sv
// Pixel source standing in for the video decoder, slave timing
`timescale 1ns/1ps
module vemi_decoder_model (
    input  wire logic       clock_i,
    input  wire logic       run_i,
    input  wire logic [9:0] lines_i,
    output logic      [7:0] pixel_o,
    output logic            hsync_n_o,
    output logic            vsync_n_o,
    output logic            drive_o
);
    // ***************************************************************
    // Forty-clock lines, Cb Y Cr Y from the hsync fall
    // ***************************************************************
    logic [5:0] col = 6'h00;
    logic [9:0] row = 10'h000;
    initial pixel_o = 8'h00;
    initial hsync_n_o = 1'b1;
    initial vsync_n_o = 1'b1;
    initial drive_o = 1'b0;
    always @(posedge clock_i) begin
        drive_o <= run_i;
        col <= (col == 6'h27) ? 6'h00 : col + 6'h01;
        if (col == 6'h27) begin
            row <= (row + 10'h001 >= lines_i) ? 10'h000 : row + 10'h001;
        end
        hsync_n_o <= !(run_i && col < 6'h04);
        vsync_n_o <= !(run_i && row < 10'h003);
        pixel_o <= {2'b01, col};
    end
endmodule

// ### test/test_video_encoder_input_mode_select.sv
// Self-checking bench for the encoder pixel input and mode select block
`timescale 1ns/1ps
`include "vemi_consts.vh"
module test_video_encoder_input_mode_select;
    // ***************************************************************
    // Stimulus, model and design
    // ***************************************************************
    logic        clock_i = 0;
    logic        reset_n_i = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, er, hs_o, hs_oe, vs_o, vs_oe;
    logic        master = 1, swap = 0, luma = 0, sleep = 0, ma = 0, mb = 0;
    logic        luma_only, pd, l625, pclk, run = 0, m_hs, m_vs, m_drv;
    logic [7:0]  pix;
    logic [9:0]  lines = 10'h12c;
    int          errors = 0, samples_checked = 0, n;
    wire hs = hs_oe ? hs_o : (m_drv ? m_hs : 1'b1);
    wire vs = vs_oe ? vs_o : (m_drv ? m_vs : 1'b1);
    always #20 clock_i = ~clock_i;
    vemi_decoder_model i_src (.clock_i(clock_i), .run_i(run), .lines_i(lines),
        .pixel_o(pix), .hsync_n_o(m_hs), .vsync_n_o(m_vs), .drive_o(m_drv));
    vemi_top i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .pixel_data_i(pix), .hsync_n_i(hs),
        .hsync_n_o(hs_o), .hsync_n_oe_o(hs_oe), .vsync_n_i(vs),
        .vsync_n_o(vs_o), .vsync_n_oe_o(vs_oe), .master_select_i(master),
        .chroma_order_swap_i(swap), .luma_select_i(luma), .sleep_i(sleep),
        .mode_pin_first_i(ma), .mode_pin_second_i(mb),
        .luma_only_o(luma_only), .powered_down_o(pd),
        .line_count_625_o(l625), .pixel_clock_out_o(pclk));
    task conclude;
        begin
            $display("Checked %0d, errors %0d", samples_checked, errors);
            if (errors == 0 && samples_checked > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            samples_checked++;
            if (got !== exp) begin
                errors++;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock_i);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge clock_i);
                n++;
            end while (pready !== 1'b1 && n < 100);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 100) begin
                errors++;
                conclude();
            end
            @(posedge clock_i);
        end
    endtask
    task t_modes;
        begin
            apb(1'b1, `VEMI_OFF_CTRL, 32'h4);
            for (int k = 0; k < 4; k++) begin
                ma <= k[0];
                mb <= k[1];
                sleep <= 1'b1;
                repeat (8) @(posedge clock_i);
                sleep <= 1'b0;
                repeat (8) @(posedge clock_i);
                apb(1'b0, `VEMI_OFF_CTRL, 32'h0);
                chk(rd, {28'h0, k[0] & k[1], 1'b0, k[1], k[0]});
            end
        end
    endtask
    task t_master;
        begin
            chk(l625, 1'b1);
            apb(1'b1, `VEMI_OFF_CTRL, 32'h0);
            repeat (4) @(posedge clock_i);
            chk(l625, 1'b0);
            apb(1'b1, `VEMI_OFF_CTRL, 32'h2);
            apb(1'b0, `VEMI_OFF_CTRL, 32'h0);
            chk(rd, 32'h2);
            chk({hs_oe, vs_oe}, 2'b11);
            chk(vs, 1'b0);
            n = 0;
            while (hs !== 1'b0 && n < 2000) begin
                @(posedge clock_i);
                n++;
            end
            chk(n < 2000, 1'b1);
            n = 0;
            while (vs !== 1'b1 && n < 6000) begin
                @(posedge clock_i);
                n++;
            end
            chk(n < 6000, 1'b1);
            apb(1'b1, `VEMI_OFF_CTRL, 32'h3);
            repeat (2) @(posedge clock_i);
            chk(vs, 1'b0);
            apb(1'b0, 12'h010, 32'h0);
            chk(er, 1'b1);
            chk(rd, 32'h0);
            luma <= 1'b1;
            repeat (6) @(posedge clock_i);
            chk(luma_only, 1'b1);
            luma <= 1'b0;
        end
    endtask
    task t_sleep;
        begin
            sleep <= 1'b1;
            repeat (6) @(posedge clock_i);
            chk({pd, pclk, hs_oe}, 3'b100);
            apb(1'b0, `VEMI_OFF_STATUS, 32'h0);
            chk({rd[4], rd[0]}, 2'b01);
            sleep <= 1'b0;
            repeat (6) @(posedge clock_i);
            chk(pd, 1'b0);
        end
    endtask
    task t_slave;
        begin
            master <= 1'b0;
            run <= 1'b1;
            repeat (24400) @(posedge clock_i);
            apb(1'b0, `VEMI_OFF_STATUS, 32'h0);
            chk({rd[5:4], rd[2], l625}, 4'b0111);
            lines <= 10'h106;
            repeat (31440) @(posedge clock_i);
            apb(1'b0, `VEMI_OFF_STATUS, 32'h0);
            chk({rd[2], l625}, 2'b00);
        end
    endtask
    task t_pixels;
        logic [7:0] first;
        begin
            for (int s = 0; s < 2; s++) begin
                swap <= s[0];
                repeat (20) @(posedge clock_i);
                repeat (6) apb(1'b0, `VEMI_OFF_PIXEL, 32'h0);
                first = s ? rd[7:0] : rd[23:16];
                chk(rd[24], 1'b1);
                chk(first & 8'h03, 8'h00);
                chk(rd[15:8], first + 8'h01);
                chk(s ? rd[23:16] : rd[7:0], first + 8'h02);
            end
        end
    endtask
    task t_rare;
        begin
            apb(1'b1, `VEMI_OFF_CTRL, 32'h8);
            master <= 1'b1;
            repeat (6) @(posedge clock_i);
            apb(1'b0, `VEMI_OFF_CTRL, 32'h0);
            chk(rd, 32'h8);
            chk({hs_oe, vs_oe}, 2'b11);
        end
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        t_modes();
        t_master();
        t_sleep();
        t_slave();
        t_pixels();
        t_rare();
        conclude();
    end
endmodule
bind vemi_top vemi_props i_props (.*);
